// ==== tb_tx_edge_shaping_guard_timer.sv ====
// Self-checking bench for the shaping and guard-time block
`timescale 1ns/10ps
module tb_tx_edge_shaping_guard_timer;
   logic clock, rst, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic txModOut, millerStart, millerPulse, waitStart, cardSide, txHold;
   logic modeDetValid, parityIn, lastByte, parityOut, sendReq, txModIn;
   logic [19:0] modeDetWait;
   logic [7:0] modeDetPrescale;
   logic [5:0] v;
   int n_mismatch, total_checks, h, m;
   localparam logic [72:0] ROWS [6] = '{
      {8'h54, 32'hffffffff, 32'hffff001f, 1'b0},
      {8'h58, 32'hffffffff, 32'h0000ffff, 1'b0},
      {8'h5c, 32'hffffffff, 32'h0fffffff, 1'b0},
      {8'h60, 32'hffffffff, 32'h00002000, 1'b0},
      {8'h44, 32'hffffffff, 32'h00000000, 1'b1},
      {8'h80, 32'hffffffff, 32'h00000000, 1'b1}};
   txgs_shaper uut (.clock(clock), .rst(rst), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .txModIn(txModIn),
      .txModOut(txModOut), .millerStart(millerStart),
      .millerPulse(millerPulse), .waitStart(waitStart), .cardSide(cardSide),
      .txHold(txHold), .modeDetValid(modeDetValid),
      .modeDetWait(modeDetWait), .modeDetPrescale(modeDetPrescale),
      .parityIn(parityIn), .lastByte(lastByte), .parityOut(parityOut));
   txgs_enc_model enc (.clock(clock), .sendReq(sendReq), .txHold(txHold),
      .txModIn(txModIn));
   //////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clock);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clock);
         if (pready === 1'b1)
            break;
      end
      if (i == 20) begin
         n_mismatch++;
         summarize();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // One-cycle strobe: 0 Miller start, 1 wait start, else detector
   task automatic pulse(input int k);
      @(posedge clock);
      case (k)
         0: millerStart <= 1'b1;
         1: waitStart <= 1'b1;
         default: modeDetValid <= 1'b1;
      endcase
      @(posedge clock);
      millerStart <= 1'b0;
      waitStart <= 1'b0;
      modeDetValid <= 1'b0;
   endtask
   task automatic cnt();
      h = 0;
      m = 0;
      repeat (200) begin
         @(posedge clock);
         h += int'(txHold);
         m += int'(millerPulse);
      end
   endtask
   task automatic shape();
      @(posedge clock);
      sendReq <= 1'b1;
      repeat (2) @(posedge clock);
      for (int k = 0; k < 6; k++) begin
         @(posedge clock);
         v = {v[4:0], txModOut};
      end
      sendReq <= 1'b0;
      repeat (20) @(posedge clock);
   endtask
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   initial begin
      rst = 1'b1;
      {psel, penable, pwrite, millerStart, waitStart, cardSide} = 6'h00;
      {modeDetValid, parityIn, lastByte, sendReq} = 4'h0;
      modeDetWait = 20'h00003;
      modeDetPrescale = 8'h02;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      foreach (ROWS[j]) begin
         apb(1'b1, ROWS[j][72:65], ROWS[j][64:33]);
         chk("wr err", {31'h0, ROWS[j][0]}, {31'h0, er});
         apb(1'b0, ROWS[j][72:65], 32'h0);
         chk("rd data", ROWS[j][32:1], rd);
      end
      $display("register rows done");
      apb(1'b1, 8'h54, 32'h50000007);
      shape();
      chk("shape on", 32'h17, {26'h0, v});
      apb(1'b1, 8'h54, 32'h50000006);
      shape();
      chk("shape off", 32'h3f, {26'h0, v});
      apb(1'b1, 8'h58, 32'h00000302);
      apb(1'b1, 8'h5c, 32'h00000201);
      pulse(0);
      cnt();
      chk("miller", 32'd4, m);
      for (int c = 1; c >= 0; c--) begin
         cardSide <= c[0];
         pulse(1);
         cnt();
         chk("hold len", 32'(4 + c), h);
      end
      apb(1'b1, 8'h5c, 32'h00000001);
      pulse(1);
      cnt();
      chk("hold zero", 32'd0, h);
      apb(1'b1, 8'h5c, 32'h0000017f);
      pulse(1);
      apb(1'b0, 8'h80, 32'h0);
      chk("stat count", 32'h00100001, rd);
      cnt();
      chk("hold dpc", 32'd125, h);
      $display("prescaler 127 done");
      pulse(2);
      apb(1'b0, 8'h5c, 32'h0);
      chk("detector", 32'h00000302, rd);
      pulse(1);
      cnt();
      chk("hold det", 32'd9, h);
      apb(1'b1, 8'h60, 32'h00002000);
      parityIn <= 1'b1;
      lastByte <= 1'b1;
      repeat (2) @(posedge clock);
      chk("parity last", 32'h0, {31'h0, parityOut});
      lastByte <= 1'b0;
      repeat (2) @(posedge clock);
      chk("parity mid", 32'h1, {31'h0, parityOut});
      $display("timer and parity done");
      rst <= 1'b1;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      for (int j = 0; j < 4; j++) begin
         apb(1'b0, ROWS[j][72:65], 32'h0);
         chk("reset val", 32'h0, rd);
      end
      $display("reset done");
      summarize();
   end
endmodule
bind txgs_shaper txgs_shaper_chk u_chk (.clock(clock), .rst(rst),
   .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .txModIn(txModIn), .txModOut(txModOut),
   .millerStart(millerStart), .millerPulse(millerPulse),
   .waitStart(waitStart), .txHold(txHold), .parityIn(parityIn),
   .lastByte(lastByte), .parityOut(parityOut));

// ==== txgs_enc_model.sv ====
// Encoder-side model that sends only when the guard wait allows
`timescale 1ns/10ps
module txgs_enc_model (
   input wire logic clock,
   input wire logic sendReq,
   input wire logic txHold,
   output logic txModIn
);
   // Holds off modulation while the guard wait runs
   always_ff @(posedge clock) begin
      txModIn <= sendReq && !txHold;
   end
endmodule

// ==== txgs_params.svh ====
// Register map, field positions, reset values and timing counts
`ifndef TXGS_PARAMS_SVH
`define TXGS_PARAMS_SVH
`define TXGS_IDX_RISE 8'h15
`define TXGS_IDX_MODT 8'h16
`define TXGS_IDX_WAIT 8'h17
`define TXGS_IDX_FRAME 8'h18
`define TXGS_IDX_STAT 8'h20
`define TXGS_RISE_PAT_HI 31
`define TXGS_RISE_PAT_LO 16
`define TXGS_RISE_LEN_HI 4
`define TXGS_RISE_LEN_LO 1
`define TXGS_RISE_EN_BIT 0
`define TXGS_MILLER_HI 15
`define TXGS_MILLER_LO 8
`define TXGS_PHASE_HI 7
`define TXGS_PHASE_LO 0
`define TXGS_WVAL_HI 27
`define TXGS_WVAL_LO 8
`define TXGS_PRESC_HI 7
`define TXGS_PRESC_LO 0
`define TXGS_PINV_BIT 13
`define TXGS_STAT_HOLD_BIT 20
`define TXGS_RST_PAT 16'h0000
`define TXGS_RST_LEN 4'h0
`define TXGS_RST_MILLER 8'h00
`define TXGS_RST_PHASE 8'h00
`define TXGS_RST_WVAL 20'h00000
`define TXGS_RST_PRESC 8'h00
`define TXGS_CARRIER_HZ 13560000
`define TXGS_PRESC_RECOMMENDED 8'h7f
`endif

// ==== txgs_pkg.sv ====
// Types shared by the transmit shaping and guard-time block
package txgs_pkg;
   typedef enum logic [2:0] {
      WT_IDLE = 3'b001,
      WT_COUNT = 3'b010,
      WT_DONE = 3'b100
   } txgs_wait_state_t;
   typedef enum logic [2:0] {
      SEL_NONE,
      SEL_RISE,
      SEL_MODT,
      SEL_WAIT,
      SEL_FRAME,
      SEL_STAT
   } txgs_reg_sel_t;
endpackage

// ==== txgs_shaper.sv ====
// Transmit edge shaping, Miller pulse width and guard-time timer
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`include "txgs_params.svh"
//////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1: Rising edge followed by programmed pattern
// RQ2: Pattern length is field plus one, MSB first
// RQ3: Shaping only while enable bit set
// RQ4: Miller pulse lasts width field plus one
// RQ5: Wait timer has prescaler and 20-bit counter
// RQ6: Prescaler decrements every carrier cycle
// RQ7: Prescaler wrap decrements main, reloads prescaler
// RQ8: Card side loads bit phase first
// RQ9: Phase, value, prescaler set inserted wait
// RQ10: Bit phase serves type A synchronisation
// RQ11: Zero wait value disables guard time
// RQ12: Mode detector overrides wait fields
// RQ13: Software should program prescaler to 127
// RQ14: Invert parity of final frame byte
// RQ15: Falling-edge counterpart uses LSB first
// RQ16: Hold transmission until main counter zero
//////////////////////////////////////////////////////////////////////////////
module txgs_shaper
   import txgs_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic txModIn,
   output logic txModOut,
   input wire logic millerStart,
   output logic millerPulse,
   input wire logic waitStart,
   input wire logic cardSide,
   output logic txHold,
   input wire logic modeDetValid,
   input wire logic [19:0] modeDetWait,
   input wire logic [7:0] modeDetPrescale,
   input wire logic parityIn,
   input wire logic lastByte,
   output logic parityOut
);

   //////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [15:0] risePattern_r;
   logic [3:0] riseLength_r;
   logic riseEnable_r;
   logic [7:0] millerWidth_r;
   logic [7:0] firstPrescale_r;
   logic [19:0] waitValue_r;
   logic [7:0] prescale_r;
   logic finalParityInv_r;
   logic [19:0] mainCnt_r;
   logic [7:0] prescCnt_r;
   txgs_wait_state_t waitState_r;

   // Byte address is four times the register index
   function automatic txgs_reg_sel_t decodeAddr(input logic [7:0] a);
      logic [7:0] idx;
      idx = {2'b00, a[7:2]};
      if (a[1:0] != 2'b00) begin
         decodeAddr = SEL_NONE;
      end else if (idx == `TXGS_IDX_RISE) begin
         decodeAddr = SEL_RISE;
      end else if (idx == `TXGS_IDX_MODT) begin
         decodeAddr = SEL_MODT;
      end else if (idx == `TXGS_IDX_WAIT) begin
         decodeAddr = SEL_WAIT;
      end else if (idx == `TXGS_IDX_FRAME) begin
         decodeAddr = SEL_FRAME;
      end else if (idx == `TXGS_IDX_STAT) begin
         decodeAddr = SEL_STAT;
      end else begin
         decodeAddr = SEL_NONE;
      end
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // APB slave: no wait states, pready raised in the access phase
   txgs_reg_sel_t sel;
   logic setupPhase;
   logic writeNow;
   logic [31:0] readMux;
   logic badAccess;

   assign sel = decodeAddr(paddr);
   assign setupPhase = psel & ~penable;
   assign writeNow = psel & penable & pready & pwrite;
   // Status is read-only, so a write there is refused like a hole
   assign badAccess = (sel == SEL_NONE) || (pwrite && sel == SEL_STAT);

   always_comb begin
      readMux = 32'h00000000;
      if (sel == SEL_RISE) begin
         readMux[`TXGS_RISE_PAT_HI:`TXGS_RISE_PAT_LO] = risePattern_r;
         readMux[`TXGS_RISE_LEN_HI:`TXGS_RISE_LEN_LO] = riseLength_r;
         readMux[`TXGS_RISE_EN_BIT] = riseEnable_r;
      end else if (sel == SEL_MODT) begin
         readMux[`TXGS_MILLER_HI:`TXGS_MILLER_LO] = millerWidth_r;
         readMux[`TXGS_PHASE_HI:`TXGS_PHASE_LO] = firstPrescale_r;
      end else if (sel == SEL_WAIT) begin
         readMux[`TXGS_WVAL_HI:`TXGS_WVAL_LO] = waitValue_r;
         readMux[`TXGS_PRESC_HI:`TXGS_PRESC_LO] = prescale_r;
      end else if (sel == SEL_FRAME) begin
         readMux[`TXGS_PINV_BIT] = finalParityInv_r;
      end else if (sel == SEL_STAT) begin
         readMux[19:0] = mainCnt_r;
         readMux[`TXGS_STAT_HOLD_BIT] = (waitState_r == WT_COUNT);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (setupPhase && !pready) begin
         pready <= 1'b1;
         pslverr <= badAccess;
         prdata <= pwrite ? 32'h00000000 : readMux;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         risePattern_r <= `TXGS_RST_PAT;
         riseLength_r <= `TXGS_RST_LEN;
         riseEnable_r <= 1'b0;
         millerWidth_r <= `TXGS_RST_MILLER;
         firstPrescale_r <= `TXGS_RST_PHASE;
         finalParityInv_r <= 1'b0;
      end else if (writeNow) begin
         if (sel == SEL_RISE) begin
            risePattern_r <= pwdata[`TXGS_RISE_PAT_HI:`TXGS_RISE_PAT_LO];
            riseLength_r <= pwdata[`TXGS_RISE_LEN_HI:`TXGS_RISE_LEN_LO];
            riseEnable_r <= pwdata[`TXGS_RISE_EN_BIT];
         end else if (sel == SEL_MODT) begin
            millerWidth_r <= pwdata[`TXGS_MILLER_HI:`TXGS_MILLER_LO];
            firstPrescale_r <= pwdata[`TXGS_PHASE_HI:`TXGS_PHASE_LO];
         end else if (sel == SEL_FRAME) begin
            finalParityInv_r <= pwdata[`TXGS_PINV_BIT];
         end
      end
   end

   // Detector update wins over a software write in the same cycle
   always_ff @(posedge clock) begin
      if (rst) begin
         waitValue_r <= `TXGS_RST_WVAL;
         prescale_r <= `TXGS_RST_PRESC;
      end else if (modeDetValid) begin
         waitValue_r <= modeDetWait; // [RQ12]
         prescale_r <= modeDetPrescale; // [RQ12]
      end else if (writeNow && sel == SEL_WAIT) begin
         waitValue_r <= pwdata[`TXGS_WVAL_HI:`TXGS_WVAL_LO];
         prescale_r <= pwdata[`TXGS_PRESC_HI:`TXGS_PRESC_LO];
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Rising-edge shaping pattern
   logic txModPrev_r;
   logic [4:0] riseLeft_r;
   logic [3:0] riseBit_r;
   logic riseEdge;
   logic riseStart;
   logic riseBusy;

   assign riseEdge = txModIn & ~txModPrev_r;
   // A new edge restarts a pattern that is still running
   assign riseStart = riseEdge & riseEnable_r; // [RQ1] [RQ3]
   assign riseBusy = (riseLeft_r != 5'h00) & riseEnable_r; // [RQ3]

   always_ff @(posedge clock) begin
      if (rst) begin
         txModPrev_r <= 1'b0;
         riseLeft_r <= 5'h00;
         riseBit_r <= 4'hf;
         txModOut <= 1'b0;
      end else begin
         txModPrev_r <= txModIn;
         if (riseStart) begin // [RQ1] [RQ3]
            // Length plus one bits, MSB first; shorter tail ignored
            riseLeft_r <= {1'b0, riseLength_r}; // [RQ2]
            riseBit_r <= 4'he;
            txModOut <= risePattern_r[15]; // [RQ1] [RQ2]
         end else if (riseBusy) begin
            riseLeft_r <= riseLeft_r - 5'h01;
            riseBit_r <= riseBit_r - 4'h1;
            txModOut <= risePattern_r[riseBit_r]; // [RQ2]
         end else begin
            // Disabling mid-pattern drops the rest at once
            riseLeft_r <= 5'h00;
            riseBit_r <= 4'hf;
            txModOut <= txModIn; // [RQ3]
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Miller pulse width
   logic [8:0] millerLeft_r;
   logic millerBusy;

   // A new start restarts a pulse that is still running at full width
   assign millerBusy = (millerLeft_r != 9'h000);

   always_ff @(posedge clock) begin
      if (rst) begin
         millerLeft_r <= 9'h000;
         millerPulse <= 1'b0;
      end else if (millerStart) begin
         millerLeft_r <= {1'b0, millerWidth_r}; // [RQ4]
         millerPulse <= 1'b1;
      end else if (millerBusy) begin
         millerLeft_r <= millerLeft_r - 9'h001;
         millerPulse <= 1'b1; // [RQ4]
      end else begin
         millerPulse <= 1'b0;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Guard-time wait timer
   logic waitLoad;
   logic prescWrap;
   logic lastPeriod;
   logic [7:0] firstLoad;

   // A zero wait value never starts the timer, so nothing is held back
   assign waitLoad = waitStart && (waitValue_r != 20'h00000); // [RQ11]
   // Bit phase trims the first period only; later reloads use prescale_r
   assign firstLoad = cardSide ? firstPrescale_r : prescale_r; // [RQ8] [RQ10]
   assign prescWrap = (prescCnt_r == 8'h00); // [RQ7]
   assign lastPeriod = prescWrap && (mainCnt_r == 20'h00001);

   always_ff @(posedge clock) begin
      if (rst) begin
         waitState_r <= WT_IDLE;
         mainCnt_r <= 20'h00000;
         prescCnt_r <= 8'h00;
         txHold <= 1'b0;
      end else begin
         case (waitState_r)
            WT_IDLE, WT_DONE: begin
               if (waitLoad) begin
                  waitState_r <= WT_COUNT;
                  mainCnt_r <= waitValue_r; // [RQ5] [RQ9]
                  prescCnt_r <= firstLoad; // [RQ8] [RQ9]
                  txHold <= 1'b1; // [RQ16]
               end else begin
                  txHold <= 1'b0; // [RQ11]
               end
            end
            WT_COUNT: begin
               if (prescWrap) begin
                  prescCnt_r <= prescale_r; // [RQ7] [RQ13]
                  mainCnt_r <= mainCnt_r - 20'h00001; // [RQ7]
               end else begin
                  prescCnt_r <= prescCnt_r - 8'h01; // [RQ6]
               end
               if (lastPeriod) begin
                  waitState_r <= WT_DONE;
                  txHold <= 1'b0; // [RQ16]
               end
            end
            default: begin
               waitState_r <= WT_IDLE;
               txHold <= 1'b0;
            end
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // Final parity inversion
   logic invertNow;

   // Earlier bytes of the frame keep their parity untouched
   assign invertNow = lastByte & finalParityInv_r; // [RQ14]

   always_ff @(posedge clock) begin
      if (rst) begin
         parityOut <= 1'b0;
      end else begin
         parityOut <= parityIn ^ invertNow; // [RQ14]
      end
   end

   // Falling-edge shaping lives in the companion block, LSB first [RQ15]
endmodule

// ==== txgs_shaper_chk.sv ====
// Port checker for the shaping and guard-time block
`timescale 1ns/10ps
module txgs_shaper_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic txModIn,
   input wire logic txModOut,
   input wire logic millerStart,
   input wire logic millerPulse,
   input wire logic waitStart,
   input wire logic txHold,
   input wire logic parityIn,
   input wire logic lastByte,
   input wire logic parityOut
);
   logic [4:0] quiet_r;
   // Pattern is at most 16 bits, so 18 quiet cycles means plain follow
   always_ff @(posedge clock) begin
      if (rst || $rose(txModIn))
         quiet_r <= 5'h00;
      else if (quiet_r != 5'h1f)
         quiet_r <= quiet_r + 5'h01;
   end
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   chk_apb_answer: assert property (psel && !penable && !pready |=> pready)
      else $error("pready late");
   chk_err_pair: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not idle");
   chk_miller_start: assert property (millerStart |=> millerPulse)
      else $error("pulse missing");
   chk_miller_cause: assert property ($rose(millerPulse)
      |-> $past(millerStart)) else $error("pulse uncaused");
   chk_hold_cause: assert property ($rose(txHold)
      |-> $past(waitStart)) else $error("hold uncaused");
   chk_parity_pass: assert property (!$past(rst) && !$past(lastByte)
      |-> parityOut == $past(parityIn)) else $error("parity altered");
   chk_mod_follow: assert property (quiet_r > 5'h11
      |-> txModOut == $past(txModIn)) else $error("mod not following");
endmodule
